// ---- rtl/itm_pkg.sv ----
// package: register offsets, field positions and reset values of the io trap monitor
package itm_pkg;
  // ----------------------------------------------------------------
  // register byte offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] SUSPEND_MONITOR_PORT = 8'hd8;
  localparam logic [7:0] SUSPEND_MONITOR_MASK = 8'hda;
  localparam logic [7:0] SUSPEND_MONITOR_COMPARE = 8'hdc;
  localparam logic [7:0] SUSPEND_MONITOR_CONTROL = 8'hde;
  localparam logic [7:0] QUICKSTART_MONITOR_PORT = 8'he0;
  localparam logic [7:0] QUICKSTART_MONITOR_MASK = 8'he2;
  localparam logic [7:0] QUICKSTART_MONITOR_COMPARE = 8'he4;
  localparam logic [7:0] QUICKSTART_MONITOR_CONTROL = 8'he6;
  // ----------------------------------------------------------------
  // control fields and reset values
  // ----------------------------------------------------------------
  localparam int WATCH_READS_BIT = 0;
  localparam int WATCH_WRITES_BIT = 1;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
endpackage : itm_pkg

// ---- rtl/itm_watch.sv ----
// one port watcher: address hit, masked compare and arm-until-stop-clock latch
module itm_watch
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // settings
  input wire logic [15:0] port_addr,
  input wire logic [15:0] mask,
  input wire logic [15:0] compare,
  input wire logic [1:0] control,
  // io cycle
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_data,
  input wire logic stop_rise,
  // result
  output logic armed_reg,
  output logic enter_reg
);
  import itm_pkg::*;

  logic hit;
  logic match;
  logic armed_next;

  // only the two low control bits are looked at
  assign hit = io_valid && (io_addr == port_addr) &&
    (io_write ? control[WATCH_WRITES_BIT] : control[WATCH_READS_BIT]);
  assign match = hit && ((io_data & mask) == compare);
  // stop clock consumes the arm; a match in the same cycle re-arms for the next one
  assign armed_next = match ? 1'b1 : (stop_rise ? 1'b0 : armed_reg);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      armed_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      armed_reg <= armed_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enter_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      enter_reg <= stop_rise && armed_reg;
    end
  end

  AST_NO_ARM_DISABLED: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && control == 2'h0 && !armed_reg |=> !armed_reg)
    else $error("watcher armed with both enables clear");
  AST_MATCH_ARMS: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && match |=> armed_reg)
    else $error("match did not arm");
  AST_ENTER_NEEDS_ARM: assert property (@(posedge sys_clk) disable iff (!rstn)
    enter_reg |-> $past(armed_reg) && $past(stop_rise))
    else $error("entered without arm and stop clock");
endmodule : itm_watch

// ---- rtl/itm_top.sv ----
// io trap power state monitor: config registers, io cycle trap, suspend/quick-start arming
// ----------------------------------------------------------------
// Summary of operation
// - a 16-bit port address is held and compared against each io cycle for power-on suspend.
// - data of a hit on the suspend port is ANDed with the suspend mask before comparing.
// - masked data equal to the suspend compare value arms suspend, entered at next stop clock.
// - control bit 1 makes io writes to the suspend port candidates, else writes are ignored.
// - control bit 0 makes io reads from the suspend port candidates, else reads are ignored.
// - only control bits 1:0 exist; bits 7:2 are reserved, read zero and do nothing.
// - a separate 16-bit port address is watched for quick-start requests.
// - quick-start data is masked, compared, and on equality armed for the next stop clock.
// - quick-start control bit 1 watches writes and bit 0 watches reads, bits 7:2 reserved.
// ----------------------------------------------------------------
module itm_top
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // configuration access, 16-bit word per aligned even offset
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata_reg,
  // processor io cycles
  input wire logic io_valid,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_data,
  // stop clock request, active high
  input wire logic stop_clock_request,
  // state outputs
  output logic suspend_pending_reg,
  output logic quickstart_pending_reg,
  output logic enter_suspend_reg,
  output logic enter_quickstart_reg
);
  import itm_pkg::*;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [15:0] suspend_port_field;
  logic [15:0] suspend_mask_field;
  logic [15:0] suspend_compare_field;
  logic [1:0] suspend_monitor_control;
  logic [15:0] quickstart_port_field;
  logic [15:0] quickstart_mask_field;
  logic [15:0] quickstart_compare_field;
  logic [1:0] quickstart_monitor_control;
  logic stop_prev_reg;
  logic stop_rise;
  logic sus_arm;
  logic qs_arm;
  logic sus_enter;
  logic qs_enter;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      suspend_port_field <= WORD_RESET;
      suspend_mask_field <= WORD_RESET;
      suspend_compare_field <= WORD_RESET;
      suspend_monitor_control <= CONTROL_RESET;
      quickstart_port_field <= WORD_RESET;
      quickstart_mask_field <= WORD_RESET;
      quickstart_compare_field <= WORD_RESET;
      quickstart_monitor_control <= CONTROL_RESET;
    end
    else if (clk_en && cfg_wr)
    begin
      unique case (cfg_addr)
        SUSPEND_MONITOR_PORT:
          suspend_port_field <= merge(suspend_port_field, cfg_wdata, cfg_be);
        SUSPEND_MONITOR_MASK:
          suspend_mask_field <= merge(suspend_mask_field, cfg_wdata, cfg_be);
        SUSPEND_MONITOR_COMPARE:
          suspend_compare_field <= merge(suspend_compare_field, cfg_wdata, cfg_be);
        SUSPEND_MONITOR_CONTROL:
          if (cfg_be[0])
          begin
            suspend_monitor_control <= cfg_wdata[1:0];
          end
        QUICKSTART_MONITOR_PORT:
          quickstart_port_field <= merge(quickstart_port_field, cfg_wdata, cfg_be);
        QUICKSTART_MONITOR_MASK:
          quickstart_mask_field <= merge(quickstart_mask_field, cfg_wdata, cfg_be);
        QUICKSTART_MONITOR_COMPARE:
          quickstart_compare_field <= merge(quickstart_compare_field, cfg_wdata, cfg_be);
        QUICKSTART_MONITOR_CONTROL:
          if (cfg_be[0])
          begin
            quickstart_monitor_control <= cfg_wdata[1:0];
          end
        default:
          ; // unmapped writes are dropped
      endcase
    end
  end

  // read data registered; unmapped offsets and reserved bits read zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_rdata_reg <= WORD_RESET;
    end
    else if (clk_en && cfg_rd)
    begin
      unique case (cfg_addr)
        SUSPEND_MONITOR_PORT: cfg_rdata_reg <= suspend_port_field;
        SUSPEND_MONITOR_MASK: cfg_rdata_reg <= suspend_mask_field;
        SUSPEND_MONITOR_COMPARE: cfg_rdata_reg <= suspend_compare_field;
        SUSPEND_MONITOR_CONTROL: cfg_rdata_reg <= {14'h0000, suspend_monitor_control};
        QUICKSTART_MONITOR_PORT: cfg_rdata_reg <= quickstart_port_field;
        QUICKSTART_MONITOR_MASK: cfg_rdata_reg <= quickstart_mask_field;
        QUICKSTART_MONITOR_COMPARE: cfg_rdata_reg <= quickstart_compare_field;
        QUICKSTART_MONITOR_CONTROL: cfg_rdata_reg <= {14'h0000, quickstart_monitor_control};
        default: cfg_rdata_reg <= WORD_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // stop clock edge
  // ----------------------------------------------------------------
  // only the assertion edge counts, a held request does not re-enter
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stop_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      stop_prev_reg <= stop_clock_request;
    end
  end
  assign stop_rise = stop_clock_request && !stop_prev_reg;

  // ----------------------------------------------------------------
  // the two watchers
  // ----------------------------------------------------------------
  itm_watch u_suspend (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .port_addr(suspend_port_field),
    .mask(suspend_mask_field),
    .compare(suspend_compare_field),
    .control(suspend_monitor_control),
    .io_valid(io_valid),
    .io_write(io_write),
    .io_addr(io_addr),
    .io_data(io_data),
    .stop_rise(stop_rise),
    .armed_reg(sus_arm),
    .enter_reg(sus_enter)
  );

  itm_watch u_quickstart (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .port_addr(quickstart_port_field),
    .mask(quickstart_mask_field),
    .compare(quickstart_compare_field),
    .control(quickstart_monitor_control),
    .io_valid(io_valid),
    .io_write(io_write),
    .io_addr(io_addr),
    .io_data(io_data),
    .stop_rise(stop_rise),
    .armed_reg(qs_arm),
    .enter_reg(qs_enter)
  );

  // outputs from flip-flops; watcher outputs are already registered
  assign suspend_pending_reg = sus_arm;
  assign quickstart_pending_reg = qs_arm;
  assign enter_suspend_reg = sus_enter;
  assign enter_quickstart_reg = qs_enter;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SUSPEND_MATCH: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && io_valid && !io_write && suspend_monitor_control[0] &&
    io_addr == suspend_port_field &&
    (io_data & suspend_mask_field) == suspend_compare_field |=> suspend_pending_reg)
    else $error("suspend read match not armed");
  AST_SUSPEND_WR_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && suspend_monitor_control == 2'h1 && io_write && !suspend_pending_reg
    |=> !suspend_pending_reg)
    else $error("suspend armed by write with writes disabled");
  AST_QS_RD_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && quickstart_monitor_control == 2'h2 && !io_write && !quickstart_pending_reg
    |=> !quickstart_pending_reg)
    else $error("quickstart armed by read with reads disabled");
  AST_QS_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && quickstart_pending_reg && !stop_rise |=> quickstart_pending_reg)
    else $error("quickstart arm dropped without stop clock");
  AST_SUS_ENTER: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && suspend_pending_reg && stop_rise |=> enter_suspend_reg)
    else $error("suspend not entered at stop clock");
  AST_CTL_RSVD: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg_rd && clk_en && cfg_addr == SUSPEND_MONITOR_CONTROL |=> cfg_rdata_reg[15:2] == 14'h0)
    else $error("reserved control bits read nonzero");
  AST_QS_ENTER: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && quickstart_pending_reg && stop_rise |=> enter_quickstart_reg)
    else $error("quickstart not entered at stop clock");

  COV_SUSPEND: cover property (@(posedge sys_clk) disable iff (!rstn) enter_suspend_reg);
  COV_QS: cover property (@(posedge sys_clk) disable iff (!rstn) enter_quickstart_reg);
  COV_BOTH: cover property (@(posedge sys_clk) disable iff (!rstn)
    suspend_pending_reg && quickstart_pending_reg);
endmodule : itm_top

// ---- testbench/itm_cpu_model.sv ----
// processor side model: io bus cycles and the stop clock request
module itm_cpu_model
(
  // clock
  input wire logic sys_clk,
  // io cycle and stop clock
  output logic io_valid,
  output logic io_write,
  output logic [15:0] io_addr,
  output logic [15:0] io_data,
  output logic stop_clock_request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    io_valid = 1'b0;
    io_write = 1'b0;
    io_addr = 16'h0000;
    io_data = 16'h0000;
    stop_clock_request = 1'b0;
  end
  task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    io_valid <= 1'b1;
    io_write <= wr;
    io_addr <= a;
    io_data <= d;
    @(posedge sys_clk);
    io_valid <= 1'b0;
    // released bus shows garbage, so a stale match cannot hide
    io_addr <= ~a;
    io_data <= ~d;
  endtask : io_cycle
  task automatic set_stop(input logic lvl);
    @(posedge sys_clk);
    stop_clock_request <= lvl;
  endtask : set_stop
endmodule : itm_cpu_model

// ---- testbench/itm_top_tb.sv ----
// self-checking bench for the io trap power state monitor
`define CHK(act, exp) \
  begin \
    checks++; \
    if ((act) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %0t got %h want %h", $time, act, exp); \
    end \
  end
module itm_top_tb
  import itm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [1:0] cfg_be = 2'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [15:0] cfg_rdata_reg;
  logic io_valid, io_write, stop_clock_request;
  logic [15:0] io_addr, io_data;
  logic susp_pend, quick_pend, susp_enter, quick_enter;
  int n_mismatch = 0;
  int checks = 0;
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  itm_cpu_model i_cpu (.sys_clk(sys_clk), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_data(io_data), .stop_clock_request(stop_clock_request));
  itm_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata_reg(cfg_rdata_reg), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_data(io_data), .stop_clock_request(stop_clock_request),
    .suspend_pending_reg(susp_pend), .quickstart_pending_reg(quick_pend),
    .enter_suspend_reg(susp_enter), .enter_quickstart_reg(quick_enter));
  // ----------------------------------------------------------------
  // bus helpers
  // ----------------------------------------------------------------
  function automatic logic pend(input logic q);
    return q ? quick_pend : susp_pend;
  endfunction : pend
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_be <= be;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask : cfg_write
  task automatic cfg_check(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_rdata_reg, exp)
  endtask : cfg_check
  task automatic trap(input logic q, input logic wr, input logic [15:0] a, input logic [15:0] d,
    input logic exp);
    i_cpu.io_cycle(wr, a, d);
    #1;
    `CHK(pend(q), exp)
  endtask : trap
  task automatic stop_take(input logic q, input logic exp);
    int n;
    logic ent;
    n = 0;
    ent = 1'b0;
    i_cpu.set_stop(1'b1);
    while (n < 4 && ent !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
      ent = q ? quick_enter : susp_enter;
      n++;
    end
    `CHK(ent, exp)
    `CHK(q ? susp_enter : quick_enter, 1'b0)
    `CHK(pend(q), 1'b0)
    if (ent !== exp)
      wrap_up();
    @(posedge sys_clk);
    #1;
    `CHK(q ? quick_enter : susp_enter, 1'b0)
    i_cpu.set_stop(1'b0);
  endtask : stop_take
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_regs();
    logic [7:0] a;
    logic [15:0] d;
    for (int i = 0; i < 8; i++)
    begin
      a = SUSPEND_MONITOR_PORT + 8'(2 * i);
      cfg_check(a, 16'h0000);
      d = 16'ha5c0 + 16'(i);
      cfg_write(a, d, 2'h3);
      // control words keep only the two enable bits
      cfg_check(a, (i % 4 == 3) ? (d & 16'h0003) : d);
    end
    cfg_write(SUSPEND_MONITOR_PORT, 16'h1177, 2'h1);
    cfg_check(SUSPEND_MONITOR_PORT, 16'ha577);
    cfg_write(8'hd0, 16'hffff, 2'h3);
    cfg_check(8'hd0, 16'h0000);
  endtask : s_regs
  task automatic s_watch(input logic q, input logic [7:0] base);
    logic [15:0] p;
    logic [15:0] m;
    p = 16'h00b2 + {15'h0000, q};
    m = 16'h0ff0;
    cfg_write(base, p, 2'h3);
    cfg_write(base + 8'h02, m, 2'h3);
    cfg_write(base + 8'h04, 16'h1234 & m, 2'h3);
    cfg_write(base + 8'h06, 16'h0002, 2'h3);
    trap(q, 1'b0, p, 16'h1234, 1'b0);
    trap(q, 1'b1, p ^ 16'h0100, 16'h1234, 1'b0);
    trap(q, 1'b1, p, 16'h1334, 1'b0);
    trap(q, 1'b1, p, 16'hf23b, 1'b1);
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(pend(q), 1'b1)
    `CHK(pend(!q), 1'b0)
    stop_take(q, 1'b1);
    cfg_write(base + 8'h06, 16'h0001, 2'h3);
    trap(q, 1'b1, p, 16'h1234, 1'b0);
    trap(q, 1'b0, p, 16'h1234, 1'b1);
    stop_take(q, 1'b1);
    cfg_write(base + 8'h06, 16'hfffc, 2'h3);
    trap(q, 1'b1, p, 16'h1234, 1'b0);
    trap(q, 1'b0, p, 16'h1234, 1'b0);
    stop_take(q, 1'b0);
  endtask : s_watch
  // a match offered while frozen is lost, the same match after the thaw arms
  task automatic s_freeze();
    cfg_write(SUSPEND_MONITOR_CONTROL, 16'h0002, 2'h3);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    trap(1'b0, 1'b1, 16'h00b2, 16'hf23b, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    trap(1'b0, 1'b1, 16'h00b2, 16'hf23b, 1'b1);
    stop_take(1'b0, 1'b1);
  endtask : s_freeze
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    s_regs();
    s_watch(1'b0, SUSPEND_MONITOR_PORT);
    s_watch(1'b1, QUICKSTART_MONITOR_PORT);
    s_freeze();
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule : itm_top_tb
